// file: src/qrs_pkg.sv
package qrs_pkg;

   // =====================================================
   // Sizes of the array and the ports.
   // =====================================================
   localparam int DATA_W    = 36;          // Widest data word.
   localparam int LANE_W    = 9;           // One byte lane with parity.
   localparam int LANES     = 4;           // Lanes in a wide word.
   localparam int ADDR_W    = 20;          // Burst address pins.
   localparam int ROW_W     = 20;          // Storage row index width.
   localparam int BURST_LEN = 4;           // Beats per burst.

   // =====================================================
   // Read timing in input clock half cycles.
   // =====================================================
   localparam int READ_LATENCY_CYCLES_X2 = 4;  // Latency 2.0 cycles.
   localparam int PIPE_LEN = READ_LATENCY_CYCLES_X2 + BURST_LEN - 1;

   // =====================================================
   // Reset values.
   // =====================================================
   localparam logic [DATA_W-1:0] Q_RESET   = 36'h000000000;
   localparam logic              CLK_PREV0 = 1'h1;  // No false edge.

   // Data organisation, caught from a strap after reset.
   typedef enum logic [2:0] {
      ORG_X36 = 3'h1,
      ORG_X18 = 3'h2,
      ORG_X9  = 3'h4
   } qrs_org_t;

   // Write burst progress.
   typedef enum logic [3:0] {
      WR_IDLE = 4'h1,
      WR_B1   = 4'h2,
      WR_B2   = 4'h4,
      WR_B3   = 4'h8
   } qrs_wr_state_t;

   // Command pins sampled at the true clock rise.
   typedef struct packed {
      logic              readSelN;
      logic              writeSelN;
      logic [ADDR_W-1:0] addr;
   } qrs_cmd_t;

   // One write beat: data and active-low lane masks.
   typedef struct packed {
      logic [DATA_W-1:0] data;
      logic [LANES-1:0]  byteMaskN;  // byte_mask3_n..byte_mask0_n.
   } qrs_wbeat_t;

   // One scheduled read beat.
   typedef struct packed {
      logic              valid;
      logic [ADDR_W-1:0] addr;
      logic [1:0]        beat;
   } qrs_rslot_t;

endpackage

// file: src/qrs_port.sv
`timescale 1ns/1ps
`default_nettype none

module qrs_port (
   input  wire logic               clk_sys,
   input  wire logic               resetn,
   input  wire logic               kClk,
   input  wire logic               kClkN,
   input  wire logic               cClk,
   input  wire logic               cClkN,
   input  wire qrs_pkg::qrs_cmd_t   cmd,
   input  wire qrs_pkg::qrs_wbeat_t wBeat,
   input  wire qrs_pkg::qrs_org_t   orgSel,
   output logic [qrs_pkg::DATA_W-1:0] qData,
   output logic                     readOeN
);
   import qrs_pkg::*;

   // =====================================================
   // Address mapping helpers.
   // =====================================================

   // Storage row of one burst beat in each organisation.
   function automatic logic [ROW_W-1:0] rowOf(
      input qrs_org_t        org,
      input logic [ADDR_W-1:0] a,
      input logic [1:0]      b);
      begin
         case (org)
            ORG_X18: rowOf = {a[18:0], b[1]};
            ORG_X9:  rowOf = a;
            default: rowOf = {a[17:0], b};
         endcase
      end
   endfunction

   // Lane enables for one write beat.
   function automatic logic [LANES-1:0] laneEn(
      input qrs_org_t        org,
      input logic [1:0]      b,
      input logic [LANES-1:0] mN);
      begin
         case (org)
            ORG_X18: laneEn = b[0] ? {~mN[1:0], 2'h0} : {2'h0, ~mN[1:0]};
            ORG_X9:  laneEn = 4'(~mN[0]) << b;
            default: laneEn = ~mN;
         endcase
      end
   endfunction

   // =====================================================
   // Storage and state.
   // =====================================================
   logic [DATA_W-1:0] mem [2**ROW_W];       // The cell array, no reset.

   logic          kPrev_ff, kNPrev_ff;      // Last sampled K pair.
   logic          cPrev_ff, cNPrev_ff;      // Last sampled C pair.
   logic          orgDone_ff, nxt_orgDone;  // Strap taken.
   qrs_org_t      org_ff, nxt_org;          // Active organisation.
   logic          lastRd_ff, nxt_lastRd;    // Read started last K rise.
   logic          lastWr_ff, nxt_lastWr;    // Write started last K rise.
   logic          pend_ff, nxt_pend;        // Write waiting for data.
   logic [ADDR_W-1:0] pendA_ff, nxt_pendA;  // Its address.
   logic [ADDR_W-1:0] wrA_ff, nxt_wrA;      // Address of running burst.
   qrs_wr_state_t wr_ff, nxt_wr;            // Write burst progress.
   qrs_rslot_t    pipe_ff [PIPE_LEN];       // Read beat schedule.
   qrs_rslot_t    nxt_pipe [PIPE_LEN];
   logic          stV_ff, nxt_stV;          // Staged beat valid.
   logic [DATA_W-1:0] stD_ff, nxt_stD;      // Staged beat data.
   logic [DATA_W-1:0] q_ff, nxt_q;          // Read data pins.
   logic          oeN_ff, nxt_oeN;          // Read driver enable, low on.

   // =====================================================
   // Edge detection on the synchronous clock pins.
   // =====================================================
   logic kRise, kNRise, pairEdge, cRise, cNRise, useK;
   logic rdCmd, wrCmd;

   always_comb begin
      kRise    = kClk & ~kPrev_ff;
      kNRise   = kClkN & ~kNPrev_ff;
      pairEdge = kRise | kNRise;
      cRise    = cClk & ~cPrev_ff;
      cNRise   = cClkN & ~cNPrev_ff;
      // Both output clocks held high hands launch to the K pair.
      useK     = cClk & cClkN;
   end

   // Clock levels are remembered for the next comparison.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         kPrev_ff  <= CLK_PREV0;
         kNPrev_ff <= CLK_PREV0;
         cPrev_ff  <= CLK_PREV0;
         cNPrev_ff <= CLK_PREV0;
      end else begin
         kPrev_ff  <= kClk;
         kNPrev_ff <= kClkN;
         cPrev_ff  <= cClk;
         cNPrev_ff <= cClkN;
      end
   end

   // =====================================================
   // Command decode at the true clock rise.
   // =====================================================

   // Selects count only at a K rise; a repeat is dropped.
   always_comb begin
      rdCmd = kRise & ~cmd.readSelN & ~lastRd_ff;
      // A read on the same edge wins over a write.
      wrCmd = kRise & ~cmd.writeSelN & ~lastWr_ff & ~rdCmd;
      // Both selects high leaves rdCmd and wrCmd low.
      nxt_lastRd  = kRise ? rdCmd : lastRd_ff;
      nxt_lastWr  = kRise ? wrCmd : lastWr_ff;
      nxt_orgDone = 1'h1;
      // The strap is caught once, at the first edge after release.
      nxt_org     = orgDone_ff ? org_ff : orgSel;
   end

   // Command history and organisation registers.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         lastRd_ff  <= 1'h0;
         lastWr_ff  <= 1'h0;
         orgDone_ff <= 1'h0;
         org_ff     <= ORG_X36;
      end else begin
         lastRd_ff  <= nxt_lastRd;
         lastWr_ff  <= nxt_lastWr;
         orgDone_ff <= nxt_orgDone;
         org_ff     <= nxt_org;
      end
   end

   // =====================================================
   // Write burst.
   // =====================================================
   logic       wrBeatEn;
   logic [1:0] wrBeat;
   logic [ADDR_W-1:0] wrBeatA;

   // Beat 0 at the K rise after the command, then /K, K, /K.
   // No edges means no change, so a stopped clock freezes it.
   always_comb begin
      nxt_wr   = wr_ff;
      nxt_wrA  = wrA_ff;
      nxt_pend = pend_ff;
      nxt_pendA = pendA_ff;
      wrBeatEn = 1'h0;
      wrBeat   = 2'h0;
      wrBeatA  = wrA_ff;
      if (kRise) begin
         case (wr_ff)
            WR_B2: begin
               wrBeatEn = 1'h1;
               wrBeat   = 2'h2;
               nxt_wr   = WR_B3;
            end
            default: begin
               if (pend_ff) begin
                  wrBeatEn = 1'h1;
                  wrBeatA  = pendA_ff;
                  nxt_wrA  = pendA_ff;
                  nxt_wr   = WR_B1;
               end
            end
         endcase
         // A new command is parked for the next K rise.
         nxt_pend = wrCmd;
         if (wrCmd) begin
            nxt_pendA = cmd.addr;
         end
      end else if (kNRise) begin
         case (wr_ff)
            WR_B1: begin
               wrBeatEn = 1'h1;
               wrBeat   = 2'h1;
               nxt_wr   = WR_B2;
            end
            WR_B3: begin
               wrBeatEn = 1'h1;
               wrBeat   = 2'h3;
               nxt_wr   = WR_IDLE;
            end
            default: begin
               nxt_wr = wr_ff;
            end
         endcase
      end
   end

   // Write burst registers.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         wr_ff    <= WR_IDLE;
         wrA_ff   <= '0;
         pend_ff  <= 1'h0;
         pendA_ff <= '0;
      end else begin
         wr_ff    <= nxt_wr;
         wrA_ff   <= nxt_wrA;
         pend_ff  <= nxt_pend;
         pendA_ff <= nxt_pendA;
      end
   end

   // Lanes and data of the current beat, masks taken fresh.
   logic [ROW_W-1:0]  wrRow;
   logic [LANES-1:0]  wrLanes;
   logic [DATA_W-1:0] wrData;

   always_comb begin
      wrRow   = rowOf(org_ff, wrBeatA, wrBeat);
      wrLanes = laneEn(org_ff, wrBeat, wBeat.byteMaskN);
      case (org_ff)
         ORG_X18: wrData = {2{wBeat.data[17:0]}};
         ORG_X9:  wrData = {4{wBeat.data[8:0]}};
         default: wrData = wBeat.data;
      endcase
   end

   // The array is written lane by lane; masked lanes keep data.
   always_ff @(posedge clk_sys) begin
      for (int l = 0; l < LANES; l++) begin
         if (wrBeatEn && wrLanes[l]) begin
            mem[wrRow][l*LANE_W +: LANE_W] <= wrData[l*LANE_W +: LANE_W];
         end
      end
   end

   // =====================================================
   // Read schedule and output.
   // =====================================================
   qrs_rslot_t        due;
   logic [DATA_W-1:0] rowD;
   logic [DATA_W-1:0] dueD;

   // Slot j holds the beat due at the (j+1)-th next pair edge.
   always_comb begin
      due = pipe_ff[0];
      for (int j = 0; j < PIPE_LEN; j++) begin
         nxt_pipe[j] = pipe_ff[j];
      end
      if (pairEdge) begin
         for (int j = 0; j < PIPE_LEN - 1; j++) begin
            nxt_pipe[j] = pipe_ff[j+1];
         end
         nxt_pipe[PIPE_LEN-1] = '0;
         if (rdCmd) begin
            for (int b = 0; b < BURST_LEN; b++) begin
               nxt_pipe[READ_LATENCY_CYCLES_X2 - 1 + b] =
                  {1'h1, cmd.addr, 2'(b)};
            end
         end
      end
   end

   // Fetch the due word and pick the addressed lanes.
   always_comb begin
      rowD = mem[rowOf(org_ff, due.addr, due.beat)];
      case (org_ff)
         ORG_X18: dueD = due.beat[0] ? {18'h0, rowD[35:18]} : {18'h0, rowD[17:0]};
         ORG_X9:  dueD = {27'h0, rowD[due.beat*LANE_W +: LANE_W]};
         default: dueD = rowD;
      endcase
   end

   // C launches the beat staged at the last pair edge, which
   // assumes C lags K; in K mode the due beat goes out at once.
   always_comb begin
      nxt_stV = stV_ff;
      nxt_stD = stD_ff;
      nxt_q   = q_ff;
      nxt_oeN = oeN_ff;
      if (pairEdge) begin
         nxt_stV = due.valid;
         nxt_stD = dueD;
      end
      if (useK) begin
         if (pairEdge) begin
            nxt_q   = due.valid ? dueD : q_ff;
            nxt_oeN = ~due.valid;
         end
      end else if (cRise || cNRise) begin
         nxt_q   = stV_ff ? stD_ff : q_ff;
         nxt_oeN = ~stV_ff;
      end
   end

   // Schedule and pin registers; reset floats the data pins.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         for (int j = 0; j < PIPE_LEN; j++) begin
            pipe_ff[j] <= '0;
         end
         stV_ff <= 1'h0;
         stD_ff <= Q_RESET;
         q_ff   <= Q_RESET;
         oeN_ff <= 1'h1;
      end else begin
         for (int j = 0; j < PIPE_LEN; j++) begin
            pipe_ff[j] <= nxt_pipe[j];
         end
         stV_ff <= nxt_stV;
         stD_ff <= nxt_stD;
         q_ff   <= nxt_q;
         oeN_ff <= nxt_oeN;
      end
   end

   assign qData   = q_ff;
   assign readOeN = oeN_ff;

endmodule

`default_nettype wire

// file: testbench/qrs_clk_model.sv
`timescale 1ns/1ps
`default_nettype none
// ========
// Controller clocks: K pair with a four-cycle period; C pair one cycle behind.
module qrs_clk_model (
   input  wire logic clk_sys,
   input  wire logic run,
   input  wire logic cMode,
   output logic      kClk,
   output logic      kClkN,
   output logic      cClk,
   output logic      cClkN
);
   logic [1:0] ph;  // Phase in the K period.
   // Idle levels at time zero: K pair complementary, C pair both high.
   initial begin
      ph = 2'h0;
      kClk = 1'b0;
      kClkN = 1'b1;
      cClk = 1'b1;
      cClkN = 1'b1;
   end
   // Levels move 1 ns after the edge, so each level holds two whole cycles.
   // A stop freezes the phase, which parks the K pair complementary, and the C pair too when cMode is set.
   always @(posedge clk_sys) begin
      #1;
      if (run) ph = ph + 2'h1;
      cClk = cMode ? kClk : 1'b1;
      cClkN = cMode ? kClkN : 1'b1;
      kClk = ph[1];
      kClkN = !ph[1];
   end
endmodule
`default_nettype wire

// file: testbench/qrs_port_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ========
// Watches the pins of the port.
module qrs_port_monitor (
   input wire logic                       clk_sys,
   input wire logic                       resetn,
   input wire logic                       kClk,
   input wire logic                       kClkN,
   input wire logic                       cClk,
   input wire logic                       cClkN,
   input wire qrs_pkg::qrs_cmd_t          cmd,
   input wire qrs_pkg::qrs_org_t          orgSel,
   input wire logic [qrs_pkg::DATA_W-1:0] qData,
   input wire logic                       readOeN
);
   import qrs_pkg::*;
   logic [3:0] prev_ff, nxt_prev;    // Last levels of K, /K, C, /C.
   logic       rdLast_ff, nxt_rdLast; // A read started on the last K rise.
   logic [3:0] since_ff, nxt_since;  // Pair edges since the last read start.
   logic [1:0] quiet_ff, nxt_quiet;  // Cycles with no clock level change.
   logic       kRise, pair, cPair, rdGo, kMode;
   // Edge finding mirrors the design: previous levels start high.
   always_comb begin
      kRise = kClk && !prev_ff[3];
      pair = kRise || (kClkN && !prev_ff[2]);
      cPair = (cClk && !prev_ff[1]) || (cClkN && !prev_ff[0]);
      kMode = cClk && cClkN;
      rdGo = kRise && !cmd.readSelN && !rdLast_ff;
      nxt_prev = {kClk, kClkN, cClk, cClkN};
      nxt_rdLast = kRise ? rdGo : rdLast_ff;
      nxt_since = rdGo ? 4'h0 : (pair && since_ff != 4'hf) ? since_ff + 4'h1 : since_ff;
      nxt_quiet = (nxt_prev != prev_ff) ? 2'h0 : quiet_ff + {1'b0, quiet_ff != 2'h3};
   end
   // Registers only.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         prev_ff <= 4'hf;
         rdLast_ff <= 1'b0;
         since_ff <= 4'hf;
         quiet_ff <= 2'h0;
      end else begin
         prev_ff <= nxt_prev;
         rdLast_ff <= nxt_rdLast;
         since_ff <= nxt_since;
         quiet_ff <= nxt_quiet;
      end
   end
   default clocking mcb @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   reset_float_a: assert property ($rose(resetn) |-> readOeN [*5])
      else $error("read port driven right after reset");
   read_first_a: assert property (kMode && $fell(readOeN) |-> since_ff == 4'h4)
      else $error("first read beat not at fourth pair edge");
   read_end_a: assert property (kMode && $rose(readOeN) |-> since_ff inside {4'h0, 4'h8})
      else $error("read burst not four beats");
   k_launch_a: assert property (kMode && $changed(qData) |-> $past(pair) || $past(pair, 2))
      else $error("read data moved without a K pair edge");
   c_launch_a: assert property (!kMode && $changed(qData) |-> $past(cPair) || $past(cPair, 2))
      else $error("read data moved without a C pair edge");
   stop_hold_a: assert property (quiet_ff == 2'h3 |-> $stable(qData) && $stable(readOeN))
      else $error("outputs moved with clocks stopped");
   half_width_a: assert property (orgSel == ORG_X18 |-> qData[35:18] == 18'h0)
      else $error("upper bits driven in half mode");
   narrow_width_a: assert property (orgSel == ORG_X9 |-> qData[35:9] == 27'h0)
      else $error("upper bits driven in narrow mode");
   cover property (rdGo && !cmd.writeSelN);
   cover property (!kMode && $fell(readOeN));
   cover property (quiet_ff == 2'h3);
endmodule
bind qrs_port qrs_port_monitor qrs_port_monitor_i (.clk_sys(clk_sys), .resetn(resetn),
   .kClk(kClk), .kClkN(kClkN), .cClk(cClk), .cClkN(cClkN), .cmd(cmd), .orgSel(orgSel),
   .qData(qData), .readOeN(readOeN));
`default_nettype wire

// file: testbench/qrs_port_bench.sv
`timescale 1ns/1ps
`default_nettype none
// ========
// Bench: controller role, expected array contents kept by key {addr, beat}.
module qrs_port_bench;
   import qrs_pkg::*;
   logic              clk_sys = 1'b0, resetn = 1'b0, run = 1'b1, cMode = 1'b0;
   logic              kClk, kClkN, cClk, cClkN, readOeN;
   logic [DATA_W-1:0] qData, wd [4];
   logic [3:0]        wm [4];
   logic [19:0]       ad [3];
   logic [DATA_W-1:0] mem [logic [21:0]];
   qrs_cmd_t          cmd = '{1'b1, 1'b1, 20'h0};
   qrs_wbeat_t        wBeat = '0;
   qrs_org_t          orgSel = ORG_X36;
   int                n_fail = 0, compares = 0, seed = 32'h379c3d33;
   always #12.5 clk_sys = !clk_sys;
   qrs_clk_model qrs_clk_model_i (.clk_sys(clk_sys), .run(run), .cMode(cMode), .kClk(kClk),
      .kClkN(kClkN), .cClk(cClk), .cClkN(cClkN));
   qrs_port qrs_port_i (.clk_sys(clk_sys), .resetn(resetn), .kClk(kClk), .kClkN(kClkN),
      .cClk(cClk), .cClkN(cClkN), .cmd(cmd), .wBeat(wBeat), .orgSel(orgSel), .qData(qData),
      .readOeN(readOeN));
   task automatic end_of_test();
      if (n_fail == 0 && compares > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic chkQ(string name, logic [DATA_W-1:0] e, logic [DATA_W-1:0] g);
      compares++;
      if (e !== g) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", name, e, g);
      end
   endtask
   task automatic chkF(string name, logic e, logic g);
      compares++;
      if (e !== g) begin
         n_fail++;
         $display("ERROR %s expected %b seen %b", name, e, g);
      end
   endtask
   function automatic logic [DATA_W-1:0] expQ(logic [21:0] k);
      return mem.exists(k) ? mem[k] : 'x;
   endfunction
   // Lanes past the organisation's width read as zero.
   function automatic logic [DATA_W-1:0] merge(logic [DATA_W-1:0] old, qrs_wbeat_t w);
      int nl;
      nl = (orgSel == ORG_X36) ? 4 : (orgSel == ORG_X18) ? 2 : 1;
      for (int i = 0; i < 4; i++)
         if (i >= nl) old[i*9 +: 9] = 9'h0;
         else if (!w.byteMaskN[i]) old[i*9 +: 9] = w.data[i*9 +: 9];
      return old;
   endfunction
   task automatic setBeats(logic full);
      for (int b = 0; b < 4; b++) begin
         wd[b] = DATA_W'({$random(seed), $random(seed)});
         wm[b] = full ? 4'h0 : 4'($random(seed));
      end
   endtask
   // Returns 2 ns after the edge that precedes a K rise.
   task automatic waitK();
      logic old;
      for (int i = 0; i < 16; i++) begin
         @(posedge clk_sys);
         old = kClk;
         #2;
         if (kClk === 1'b1 && old === 1'b0) return;
      end
      n_fail++;
      end_of_test();
   endtask
   // One command; reps 2 repeats the select on the next K rise.
   task automatic op(logic rdN, logic wrN, logic [19:0] a, int reps);
      waitK();
      cmd = '{rdN, wrN, a};
      if (!wrN && rdN)
         for (int b = 0; b < 4; b++) mem[{a, 2'(b)}] = merge(expQ({a, 2'(b)}), '{wd[b], wm[b]});
      fork
         begin
            @(posedge clk_sys);
            #2;
            if (reps > 1) begin
               cmd.addr = a ^ 20'h1;
               repeat (4) @(posedge clk_sys);
               #2;
            end
            cmd = '{1'b1, 1'b1, a ^ 20'h1};
         end
         begin
            @(posedge clk_sys);
            for (int b = 0; b < 5; b++) begin
               repeat (2) @(posedge clk_sys);
               #2;
               if (b < 4) begin
                  wBeat = '{wd[b], wm[b]};
               end else begin
                  wBeat = '{DATA_W'($random(seed)), 4'h0};
               end
            end
         end
         if (!rdN) begin
            repeat (10 + cMode) @(posedge clk_sys);
            for (int b = 0; b < 5; b++) begin
               @(negedge clk_sys);
               chkF("readOeN", b == 4, readOeN);
               if (b < 4) chkQ("qData", expQ({a, 2'(b)}), qData);
               repeat (2) @(posedge clk_sys);
            end
            // Leave off the edge so the next drive never races the clock.
            #2;
         end
      join
   endtask
   initial begin
      #200000;
      n_fail++;
      end_of_test();
   end
   // Each organisation runs after its own reset; the half mode uses the C pair.
   initial begin
      for (int o = 0; o < 3; o++) begin
         resetn = 1'b0;
         orgSel = (o == 0) ? ORG_X36 : (o == 1) ? ORG_X18 : ORG_X9;
         cMode = (o == 1);
         mem.delete();
         repeat (10) @(posedge clk_sys);
         #2;
         resetn = 1'b1;
         @(negedge clk_sys);
         chkF("readOeN", 1'b1, readOeN);
         for (int i = 0; i < 3; i++) begin
            ad[i] = 20'($random(seed)) & 20'h3ffff;
            setBeats(1'b1);
            op(1'b1, 1'b0, ad[i], 1);
         end
         setBeats(1'b0);
         wm[0] = 4'hf;
         op(1'b1, 1'b0, ad[1], 1);
         for (int i = 0; i < 3; i++) op(1'b0, 1'b1, ad[i], 1);
         op(1'b0, 1'b1, ad[0], 2);
         setBeats(1'b1);
         op(1'b0, 1'b0, ad[2], 1);
         op(1'b1, 1'b1, ad[0], 1);
         op(1'b0, 1'b1, ad[2], 1);
         op(1'b0, 1'b1, ad[0], 1);
         run = 1'b0;
         repeat (20) @(posedge clk_sys);
         #2;
         chkQ("qData held", expQ({ad[0], 2'h3}), qData);
         chkF("readOeN held", 1'b1, readOeN);
         run = 1'b1;
         op(1'b0, 1'b1, ad[1], 1);
      end
      end_of_test();
   end
endmodule
`default_nettype wire
